// >>> hw/clkmul_pkg.sv
// package: register map, fields, reset values and codes of the clock multiplier block
package clkmul_pkg;
  // register byte offsets on the Avalon-MM bus (word index times four)
  localparam logic [3:0] MULT_CTRL_OFS = 4'h0;
  localparam logic [3:0] XOSC_CTRL_OFS = 4'h4;
  localparam logic [3:0] MULT_STAT_OFS = 4'h8;
  // multiplier control fields
  localparam int EN_POS     = 7;
  localparam int INIT_POS   = 6;
  localparam int RDY_POS    = 5;
  localparam int SCALE_LSB  = 2;
  localparam int SRC_LSB    = 0;
  // external oscillator control fields
  localparam int VALID_POS  = 7;
  localparam int MODE_LSB   = 4;
  localparam int RANGE_LSB  = 0;
  // reset values
  localparam logic [7:0] MULT_CTRL_RST = 8'h00;
  localparam logic [7:0] XOSC_CTRL_RST = 8'h00;
  // source select codes
  localparam logic [1:0] SRC_INT_X2 = 2'h0;
  localparam logic [1:0] SRC_EXT_X2 = 2'h1;
  localparam logic [1:0] SRC_INT_X4 = 2'h2;
  localparam logic [1:0] SRC_EXT_X4 = 2'h3;
  // output scale: codes at or below this scale by one
  localparam logic [2:0] SCALE_UNITY_MAX = 3'h2;
  // external oscillator mode codes
  localparam logic [2:0] XMODE_OFF    = 3'h0;
  localparam logic [2:0] XMODE_CMOS   = 3'h2;
  localparam logic [2:0] XMODE_CMOS2  = 3'h3;
  localparam logic [2:0] XMODE_RC     = 3'h4;
  localparam logic [2:0] XMODE_CAP    = 3'h5;
  localparam logic [2:0] XMODE_XTAL   = 3'h6;
  localparam logic [2:0] XMODE_OSC_DRIVE_PIN  = 3'h7;
  // settle time after initialise before ready
  localparam int SETTLE_NS     = 5000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// >>> hw/clkmul_cfg_if.sv
// interface: multiplier settings passed from the register file to the ratio decoder
`timescale 1ns/1ps
interface clkmul_cfg_if;
  logic [1:0] src;
  logic [2:0] scale;
  logic       use_ext;
  logic [3:0] ratio_num;
  logic [3:0] ratio_den;
  modport regs (output src, output scale, input use_ext, input ratio_num, input ratio_den);
  modport dec  (input src, input scale, output use_ext, output ratio_num, output ratio_den);
endinterface

// >>> hw/clkmul_ratio.sv
// module: decodes source and scale fields into the overall clock ratio
`timescale 1ns/1ps
module clkmul_ratio
(
  clkmul_cfg_if.dec cfg
);
  logic [3:0] mult;

  always_comb
  begin
    cfg.use_ext = cfg.src[0];
    mult        = cfg.src[1] ? 4'h4 : 4'h2;
    if (cfg.src == clkmul_pkg::SRC_INT_X2)
    begin
      // doubled internal ignores the scale field
      cfg.ratio_num = 4'h2;
      cfg.ratio_den = 4'h1;
    end
    else if (cfg.scale <= clkmul_pkg::SCALE_UNITY_MAX)
    begin
      cfg.ratio_num = mult;
      cfg.ratio_den = 4'h1;
    end
    else
    begin
      // scale by 2/N
      cfg.ratio_num = 4'(mult << 1);
      cfg.ratio_den = {1'b0, cfg.scale};
    end
  end
endmodule // clkmul_ratio

// >>> hw/clkmul_top.sv
// module: clock multiplier source/scale registers and oscillator pin claiming
`timescale 1ns/1ps
module clkmul_top
#(
  parameter int SETTLE_CYC = clkmul_pkg::SETTLE_CYC
)
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // avalon-mm slave
  input  wire logic [3:0] avs_address_i,
  input  wire logic       avs_read_i,
  input  wire logic       avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0] avs_byteenable_i,
  output logic [31:0]     avs_readdata_o,
  output logic            avs_waitrequest_o,
  // multiplier outputs
  output logic            mult_use_ext_o,
  output logic [3:0]      mult_ratio_num_o,
  output logic [3:0]      mult_ratio_den_o,
  output logic            multiplier_ready_flag_o,
  // oscillator pin ownership
  output logic            osc_input_pin_claim_o,
  output logic            osc_drive_pin_claim_o
);
  clkmul_cfg_if cfg ();

  logic [7:0]  mctl_q;
  logic [6:0]  xctl_q;
  logic        init_q;
  logic        rdy_q;
  logic [15:0] settle_q;
  logic        wr_go;
  logic        rd_go;
  logic        wr_mctl;
  logic        prev_en_q;
  logic [2:0]  xmode;

  assign cfg.src   = mctl_q[1:0];
  assign cfg.scale = mctl_q[4:2];
  assign xmode     = xctl_q[6:4];

  clkmul_ratio u_ratio
  (
    .cfg (cfg)
  );

  // reads load data in the wait cycle; writes land at the edge with waitrequest low
  assign wr_go   = avs_write_i && !avs_waitrequest_o;
  assign rd_go   = avs_read_i && avs_waitrequest_o;
  assign wr_mctl = wr_go && avs_address_i == clkmul_pkg::MULT_CTRL_OFS && avs_byteenable_i[0];

  // idles high, drops for the one cycle in which a request is taken
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      avs_waitrequest_o <= 1'b1;
    else
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      mctl_q <= clkmul_pkg::MULT_CTRL_RST;
      xctl_q <= clkmul_pkg::XOSC_CTRL_RST[6:0];
    end
    else if (wr_go && avs_byteenable_i[0])
    begin
      if (avs_address_i == clkmul_pkg::MULT_CTRL_OFS)
        mctl_q <= {avs_writedata_i[7:6], 1'b0, avs_writedata_i[4:0]};
      else if (avs_address_i == clkmul_pkg::XOSC_CTRL_OFS)
        xctl_q <= {avs_writedata_i[6:4], 1'b0, avs_writedata_i[2:0]};
    end
  end

  // initialise is accepted only once enabled; settle counter then gates ready
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      init_q    <= 1'b0;
      rdy_q     <= 1'b0;
      settle_q  <= '0;
      prev_en_q <= 1'b0;
    end
    else
    begin
      prev_en_q <= mctl_q[clkmul_pkg::EN_POS];
      if (!mctl_q[clkmul_pkg::EN_POS] || wr_mctl && !avs_writedata_i[clkmul_pkg::INIT_POS])
      begin
        init_q   <= 1'b0;
        rdy_q    <= 1'b0;
        settle_q <= '0;
      end
      else if (wr_mctl && avs_writedata_i[clkmul_pkg::INIT_POS] && prev_en_q && !init_q)
      begin
        init_q   <= 1'b1;
        settle_q <= 16'(SETTLE_CYC);
      end
      else if (init_q && settle_q != 16'h0000)
        settle_q <= settle_q - 16'h0001;
      else if (init_q)
        rdy_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      avs_readdata_o <= '0;
    else if (rd_go)
    begin
      case (avs_address_i)
        clkmul_pkg::MULT_CTRL_OFS: avs_readdata_o <= {24'h000000, mctl_q[7], init_q, rdy_q, mctl_q[4:0]};
        clkmul_pkg::XOSC_CTRL_OFS: avs_readdata_o <= {24'h000000, 1'b0, xctl_q};
        clkmul_pkg::MULT_STAT_OFS: avs_readdata_o <= {24'h000000, 2'h0, rdy_q, 5'h00};
        default:                   avs_readdata_o <= '0;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      mult_use_ext_o          <= 1'b0;
      mult_ratio_num_o        <= 4'h2;
      mult_ratio_den_o        <= 4'h1;
      multiplier_ready_flag_o <= 1'b0;
    end
    else
    begin
      mult_use_ext_o          <= cfg.use_ext;
      mult_ratio_num_o        <= cfg.ratio_num;
      mult_ratio_den_o        <= cfg.ratio_den;
      multiplier_ready_flag_o <= rdy_q;
    end
  end

  // pin claiming by oscillator mode
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      osc_input_pin_claim_o <= 1'b0;
      osc_drive_pin_claim_o <= 1'b0;
    end
    else
    begin
      case (xmode)
        clkmul_pkg::XMODE_XTAL, clkmul_pkg::XMODE_OSC_DRIVE_PIN:
        begin
          osc_input_pin_claim_o <= 1'b1;
          osc_drive_pin_claim_o <= 1'b1;
        end
        clkmul_pkg::XMODE_CMOS, clkmul_pkg::XMODE_CMOS2, clkmul_pkg::XMODE_RC,
        clkmul_pkg::XMODE_CAP:
        begin
          osc_input_pin_claim_o <= 1'b0;
          osc_drive_pin_claim_o <= 1'b1;
        end
        default:
        begin
          osc_input_pin_claim_o <= 1'b0;
          osc_drive_pin_claim_o <= 1'b0;
        end
      endcase
    end
  end

  a_int_x2_fixed: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(mctl_q[1:0]) == clkmul_pkg::SRC_INT_X2 |->
    mult_ratio_num_o == 4'h2 && mult_ratio_den_o == 4'h1 && !mult_use_ext_o)
    else $error("int x2 not fixed");
  a_ext_select: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) |-> mult_use_ext_o == $past(mctl_q[0]))
    else $error("source select wrong");
  a_x4_unscaled: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) && $past(mctl_q[1]) &&
    $past(mctl_q[4:2]) <= clkmul_pkg::SCALE_UNITY_MAX |->
    mult_ratio_num_o == 4'h4 && mult_ratio_den_o == 4'h1)
    else $error("x4 ratio wrong");
  a_scale_ratio: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) && $past(mctl_q[1:0]) != 2'h0 && $past(mctl_q[4:2]) > 3'h2 |->
    mult_ratio_den_o == {1'b0, $past(mctl_q[4:2])})
    else $error("scale ratio wrong");
  a_ready_needs_en: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rdy_q |-> mctl_q[clkmul_pkg::EN_POS] && init_q)
    else $error("ready without enable");
  a_ready_settled: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(rdy_q) |-> $past(init_q) && $past(settle_q) == 16'h0000)
    else $error("ready before settling");
  a_ready_output: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) |-> multiplier_ready_flag_o == $past(rdy_q))
    else $error("ready flag lags");
  a_xtal_pins: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) && $past(xctl_q[6:5]) == 2'h3 |-> osc_input_pin_claim_o && osc_drive_pin_claim_o)
    else $error("crystal pins not claimed");
  a_one_pin_modes: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) && ($past(xctl_q[6:4]) inside {[3'h2:3'h5]}) |->
    !osc_input_pin_claim_o && osc_drive_pin_claim_o)
    else $error("single pin mode wrong");
  a_off_no_claim: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) && $past(xctl_q[6:5]) == 2'h0 |-> !osc_input_pin_claim_o && !osc_drive_pin_claim_o)
    else $error("pins claimed while off");
endmodule // clkmul_top

// >>> test/osc_partner.sv
// stand-in for the external oscillator: drives claimed pins from cnt_q[1] and released pins from cnt_q[0]
`timescale 1ns/1ps
module osc_partner
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // pin ownership from the block
  input  wire logic in_claim_i,
  input  wire logic drv_claim_i,
  // pin levels
  output logic      in_pin_o,
  output logic      drv_pin_o
);
  logic [1:0] cnt_q;
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      cnt_q <= 2'h0;
    else
      cnt_q <= cnt_q + 2'h1;
  end
  // claimed pins carry only the oscillator
  // released pins toggle every cycle so no stale level survives
  assign in_pin_o  = in_claim_i ? cnt_q[1] : cnt_q[0];
  assign drv_pin_o = drv_claim_i ? ~cnt_q[1] : cnt_q[0];
endmodule // osc_partner

// >>> test/clock_mult_source_and_xosc_pins_tb.sv
// self-checking bench for multiplier source, scale, ready and pin claiming
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin mismatches++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, gt); end end
module clock_mult_source_and_xosc_pins_tb;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [3:0]  avs_address_i = 4'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        mult_use_ext_o;
  logic [3:0]  mult_ratio_num_o;
  logic [3:0]  mult_ratio_den_o;
  logic        multiplier_ready_flag_o;
  logic        osc_input_pin_claim_o;
  logic        osc_drive_pin_claim_o;
  int          mismatches = 0;
  int          n_compared = 0;
  logic [31:0] rd;
  logic [7:0]  v;
  logic [7:0]  en;
  logic [7:0]  ed;

  clkmul_top #(.SETTLE_CYC(2)) clkmul_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .mult_use_ext_o(mult_use_ext_o), .mult_ratio_num_o(mult_ratio_num_o),
    .mult_ratio_den_o(mult_ratio_den_o), .multiplier_ready_flag_o(multiplier_ready_flag_o),
    .osc_input_pin_claim_o(osc_input_pin_claim_o),
    .osc_drive_pin_claim_o(osc_drive_pin_claim_o));
  osc_partner osc_partner_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .in_claim_i(osc_input_pin_claim_o),
    .drv_claim_i(osc_drive_pin_claim_o), .in_pin_o(), .drv_pin_o());

  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    avs_writedata_i <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    `CHK("wait_cycles", 2, n)
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  // expected ratio as numerator and denominator
  function automatic logic [15:0] exp_ratio(input logic [1:0] src, input logic [2:0] sc);
    logic [7:0] f;
    f = src[1] ? 8'h04 : 8'h02;
    if (src == clkmul_pkg::SRC_INT_X2 || sc <= clkmul_pkg::SCALE_UNITY_MAX)
      return {f, 8'h01};
    return {f * 8'h02, 5'h00, sc};
  endfunction

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    final_report;
  end

  initial
  begin
    v = 8'($urandom(32'h58d93a35));
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int s = 0; s < 32; s++)
    begin
      bus(1'b1, clkmul_pkg::MULT_CTRL_OFS, 8'(s));
      bus(1'b0, clkmul_pkg::MULT_CTRL_OFS, 8'h00);
      {en, ed} = exp_ratio(2'(s), 3'(s >> 2));
      `CHK("ctrl", 8'(s), rd[7:0])
      `CHK("use_ext", s[0], mult_use_ext_o)
      `CHK("ratio", {4'h0, mult_ratio_num_o} * ed, {4'h0, mult_ratio_den_o} * en)
    end
    for (int m = 0; m < 8; m++)
    begin
      v = 8'(m << 4) | 8'($urandom_range(7));
      bus(1'b1, clkmul_pkg::XOSC_CTRL_OFS, v | 8'h88);
      bus(1'b0, clkmul_pkg::XOSC_CTRL_OFS, 8'h00);
      `CHK("xosc", v, rd[7:0])
      `CHK("in_claim", m >= 6, osc_input_pin_claim_o)
      `CHK("drv_claim", m >= 2, osc_drive_pin_claim_o)
    end
    // a write with lane 0 disabled must leave the register alone
    avs_byteenable_i <= 4'hE;
    bus(1'b1, clkmul_pkg::XOSC_CTRL_OFS, 8'h00);
    avs_byteenable_i <= 4'hF;
    bus(1'b0, clkmul_pkg::XOSC_CTRL_OFS, 8'h00);
    `CHK("lane_off", v, rd[7:0])
    bus(1'b1, clkmul_pkg::MULT_CTRL_OFS, 8'h40);
    repeat (8) @(posedge clk_i);
    `CHK("rdy_noen", 1'b0, multiplier_ready_flag_o)
    bus(1'b1, clkmul_pkg::MULT_CTRL_OFS, 8'h80);
    bus(1'b1, clkmul_pkg::MULT_CTRL_OFS, 8'hC0);
    `CHK("rdy_early", 1'b0, multiplier_ready_flag_o)
    rd = 32'h0;
    for (int i = 0; i < 10 && rd[5] !== 1'b1; i++)
      bus(1'b0, clkmul_pkg::MULT_STAT_OFS, 8'h00);
    `CHK("rdy_stat", 1'b1, rd[5])
    `CHK("rdy_flag", 1'b1, multiplier_ready_flag_o)
    bus(1'b1, clkmul_pkg::MULT_CTRL_OFS, 8'h00);
    bus(1'b0, clkmul_pkg::MULT_STAT_OFS, 8'h00);
    `CHK("rdy_clear", 1'b0, rd[5])
    bus(1'b1, clkmul_pkg::MULT_CTRL_OFS, 8'h11);
    bus(1'b1, clkmul_pkg::MULT_CTRL_OFS, 8'h91);
    bus(1'b1, clkmul_pkg::MULT_CTRL_OFS, 8'hD1);
    rd = 32'h0;
    for (int i = 0; i < 10 && rd[5] !== 1'b1; i++)
      bus(1'b0, clkmul_pkg::MULT_STAT_OFS, 8'h00);
    bus(1'b0, clkmul_pkg::MULT_CTRL_OFS, 8'h00);
    `CHK("reinit", 8'hF1, rd[7:0])
    `CHK("ext_sel", 1'b1, mult_use_ext_o)
    `CHK("half_num", 4'h4, mult_ratio_num_o)
    `CHK("half_den", 4'h4, mult_ratio_den_o)
    bus(1'b0, 4'hC, 8'h00);
    `CHK("unmapped", 32'h0, rd)
    final_report;
  end
endmodule // clock_mult_source_and_xosc_pins_tb
